/* rpfc_pkg.sv */
// shared constants and types for the reset and power-fail control block
`default_nettype none
package rpfc_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RST_MIN_PERIODS = 8;
  localparam int unsigned STARTUP_MS = 64;
  localparam longint unsigned STARTUP_CYC_DEF = (64'(STARTUP_MS) * 64'(CLK_HZ) + 64'd999) / 64'd1000;
  localparam int unsigned STARTUP_EXTRA = 7;
  localparam int unsigned PF_FILTER_NS = 100;
  localparam int unsigned PF_CYC = (PF_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned LOW_W = 4;
  localparam int unsigned PF_W = 4;
  // reset vector addresses
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;
  // register byte offsets
  localparam logic [7:0] OFS_PFCTRL = 8'h00;
  localparam logic [7:0] OFS_CLKCTRL = 8'h04;
  localparam logic [7:0] OFS_COREINIT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // power-fail control fields
  localparam int unsigned PF_EN_BIT = 0;
  localparam int unsigned PF_RESP_BIT = 1;
  localparam int unsigned PF_OFF_BIT = 2;
  // clock control fields
  localparam int unsigned CK_WDT_RST_BIT = 0;
  localparam int unsigned CK_SUB_CLK_BIT = 1;
  // core init fields
  localparam int unsigned CI_RPR_LSB = 0;
  localparam int unsigned CI_DP_BIT = 8;
  localparam int unsigned CI_PCLK_BIT = 9;
  localparam int unsigned CI_WDT_BIT = 10;
  // status fields
  localparam int unsigned ST_EXT_BIT = 0;
  localparam int unsigned ST_WDT_BIT = 1;
  localparam int unsigned ST_PF_BIT = 2;
  localparam int unsigned ST_FRZ_BIT = 3;
  localparam int unsigned ST_RUN_BIT = 4;
  localparam int unsigned ST_LVL_LSB = 5;

  typedef struct packed {
    logic detect_off;
    logic response_reset;
    logic enable;
  } rpfc_pfctrl_t;

  typedef struct packed {
    logic sub_clk;
    logic wdt_reset_sel;
  } rpfc_clkctrl_t;

  typedef struct packed {
    logic wdt_en;
    logic periph_clk_en;
    logic dp_flag;
    logic [7:0] ram_page;
  } rpfc_coreinit_t;

  typedef struct packed {
    logic ext;
    logic wdt;
    logic pf;
  } rpfc_cause_t;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_WAIT,
    ST_VLO,
    ST_VHI,
    ST_GLO,
    ST_GHI,
    ST_RUN
  } rpfc_state_t;
endpackage
`default_nettype wire

/* rpfc_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`default_nettype none
module rpfc_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // change counts once stages two and three agree
      always_comb begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      out_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule
`default_nettype wire

/* rpfc_top.sv */
// reset and power-fail control with ahb-lite register slave
// What this block does
// - pin and watchdog reset initialise identically
// - wait 64ms plus seven periods before run
// - load pc from FFFF high, FFFE low
// - reset clears page, flag, clocks, watchdog, detector
// - data ram untouched; only control state reinitialised
// - control bits enable or disable detection
// - supply low 100ns resets or freezes core
// - threshold from config bits or mask option
// - watchdog expiry resets when select bit set
//
// Implementation choices: register access over AHB-Lite and the address map.
`default_nettype none
module rpfc_top #(
  parameter int unsigned STARTUP_CYC = 32'(rpfc_pkg::STARTUP_CYC_DEF),
  parameter logic [1:0] MASK_LEVEL = 2'h0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reset_pin_n,
  input wire logic supply_low,
  input wire logic wdt_expire,
  input wire logic otp_part,
  input wire logic cfg_fail_level_lo,
  input wire logic cfg_fail_level_hi,
  input wire logic [7:0] vec_data,
  output logic vec_rd,
  output logic [15:0] vec_addr,
  output logic [15:0] pc_value,
  output logic pc_load,
  output logic core_reset,
  output logic ctrl_init,
  output logic core_freeze,
  output logic [7:0] ram_page_reg,
  output logic dp_flag,
  output logic sub_clk_sel,
  output logic periph_clk_en,
  output logic wdt_enable,
  output logic detect_active,
  output logic fail_level_sel_lo,
  output logic fail_level_sel_hi
);
  localparam int unsigned WAIT_LAST = STARTUP_CYC + rpfc_pkg::STARTUP_EXTRA - 1;

  logic [1:0] pins;

  // pin inputs through three-stage synchroniser
  rpfc_sync #(.W(2), .RST_VAL(2'h1)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({supply_low, reset_pin_n}),
    .dout(pins)
  );

  wire pin_low = ~pins[0];
  wire supply_bad = pins[1];

  function automatic logic [31:0] rd_mux(input logic [7:0] ofs, input logic [31:0] pf, input logic [31:0] ck,
                                         input logic [31:0] ci, input logic [31:0] st);
    case (ofs)
      rpfc_pkg::OFS_PFCTRL: rd_mux = pf;
      rpfc_pkg::OFS_CLKCTRL: rd_mux = ck;
      rpfc_pkg::OFS_COREINIT: rd_mux = ci;
      rpfc_pkg::OFS_STATUS: rd_mux = st;
      default: rd_mux = 32'h0;
    endcase
  endfunction

  // register and sequence state
  rpfc_pkg::rpfc_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [rpfc_pkg::LOW_W-1:0] low_q, low_d;
  logic [rpfc_pkg::PF_W-1:0] pfc_q, pfc_d;
  rpfc_pkg::rpfc_pfctrl_t pfctrl_q, pfctrl_d;
  rpfc_pkg::rpfc_clkctrl_t clkctrl_q, clkctrl_d;
  rpfc_pkg::rpfc_coreinit_t ci_q, ci_d;
  rpfc_pkg::rpfc_cause_t cause_q, cause_d;
  logic [7:0] vlo_q, vlo_d;
  logic [15:0] pc_q, pc_d;
  logic pcl_q, pcl_d;
  logic vrd_q, vrd_d;
  logic [15:0] vad_q, vad_d;
  logic init_q, init_d;
  logic frz_q, frz_d;
  logic [1:0] lvl_q, lvl_d;
  logic wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic [31:0] rd_q, rd_d;
  logic det_q, det_d;

  logic det_on, pf_hit, ext_acc, wdt_rst, pf_rst, trig;
  logic addr_ok;
  logic [31:0] pf_word, ck_word, ci_word, st_word;

  always_comb begin
    det_on = pfctrl_q.enable & ~pfctrl_q.detect_off;
    pf_hit = det_on && (32'(pfc_q) >= rpfc_pkg::PF_CYC);
    // this cycle counts as the last of the required low periods
    ext_acc = pin_low && (32'(low_q) >= rpfc_pkg::RST_MIN_PERIODS - 1);
    wdt_rst = wdt_expire & clkctrl_q.wdt_reset_sel;
    pf_rst = pf_hit & pfctrl_q.response_reset;
    trig = ext_acc | wdt_rst | pf_rst;
    pf_word = 32'h0;
    pf_word[rpfc_pkg::PF_EN_BIT] = pfctrl_q.enable;
    pf_word[rpfc_pkg::PF_RESP_BIT] = pfctrl_q.response_reset;
    pf_word[rpfc_pkg::PF_OFF_BIT] = pfctrl_q.detect_off;
    ck_word = 32'h0;
    ck_word[rpfc_pkg::CK_WDT_RST_BIT] = clkctrl_q.wdt_reset_sel;
    ck_word[rpfc_pkg::CK_SUB_CLK_BIT] = clkctrl_q.sub_clk;
    ci_word = 32'h0;
    ci_word[rpfc_pkg::CI_RPR_LSB +: 8] = ci_q.ram_page;
    ci_word[rpfc_pkg::CI_DP_BIT] = ci_q.dp_flag;
    ci_word[rpfc_pkg::CI_PCLK_BIT] = ci_q.periph_clk_en;
    ci_word[rpfc_pkg::CI_WDT_BIT] = ci_q.wdt_en;
    st_word = 32'h0;
    st_word[rpfc_pkg::ST_EXT_BIT] = cause_q.ext;
    st_word[rpfc_pkg::ST_WDT_BIT] = cause_q.wdt;
    st_word[rpfc_pkg::ST_PF_BIT] = cause_q.pf;
    st_word[rpfc_pkg::ST_FRZ_BIT] = frz_q;
    st_word[rpfc_pkg::ST_RUN_BIT] = (state_q == rpfc_pkg::ST_RUN);
    st_word[rpfc_pkg::ST_LVL_LSB +: 2] = lvl_q;
  end

  // reset sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    vlo_d = vlo_q;
    pc_d = pc_q;
    pcl_d = 1'b0;
    vrd_d = 1'b0;
    vad_d = vad_q;
    init_d = 1'b0;
    cause_d = cause_q;
    // low-time counter saturates, clears on high
    low_d = pin_low ? ((32'(low_q) >= rpfc_pkg::RST_MIN_PERIODS) ? low_q : low_q + 1'b1) : '0;
    // supply filter counts while detection is active and supply is low, clears otherwise
    if (det_on && supply_bad) begin
      pfc_d = (32'(pfc_q) >= rpfc_pkg::PF_CYC) ? pfc_q : pfc_q + 1'b1;
    end else begin
      pfc_d = '0;
    end
    frz_d = pf_hit & ~pfctrl_q.response_reset;
    lvl_d = otp_part ? {cfg_fail_level_hi, cfg_fail_level_lo} : MASK_LEVEL;
    if (trig) begin
      state_d = rpfc_pkg::ST_HOLD;
      cnt_d = 32'h0;
      init_d = 1'b1;
      cause_d.ext = ext_acc;
      cause_d.wdt = wdt_rst;
      cause_d.pf = pf_rst;
    end else begin
      case (state_q)
        rpfc_pkg::ST_HOLD: begin
          cnt_d = 32'h0;
          if (!pin_low) begin
            state_d = rpfc_pkg::ST_WAIT;
          end
        end
        rpfc_pkg::ST_WAIT: begin
          if (cnt_q >= WAIT_LAST) begin
            state_d = rpfc_pkg::ST_VLO;
          end else begin
            cnt_d = cnt_q + 32'h1;
          end
        end
        rpfc_pkg::ST_VLO: begin
          vrd_d = 1'b1;
          vad_d = rpfc_pkg::VEC_LO_ADDR;
          state_d = rpfc_pkg::ST_VHI;
        end
        rpfc_pkg::ST_VHI: begin
          vrd_d = 1'b1;
          vad_d = rpfc_pkg::VEC_HI_ADDR;
          state_d = rpfc_pkg::ST_GLO;
        end
        rpfc_pkg::ST_GLO: begin
          vlo_d = vec_data;
          state_d = rpfc_pkg::ST_GHI;
        end
        rpfc_pkg::ST_GHI: begin
          pc_d = {vec_data, vlo_q};
          pcl_d = 1'b1;
          state_d = rpfc_pkg::ST_RUN;
        end
        rpfc_pkg::ST_RUN: begin
          state_d = rpfc_pkg::ST_RUN;
        end
        default: begin
          state_d = rpfc_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // ahb-lite slave, zero wait states
  always_comb begin
    addr_ok = hsel && hready && (htrans == rpfc_pkg::HTRANS_NONSEQ);
    wr_d = addr_ok & hwrite;
    wa_d = addr_ok ? haddr[7:0] : wa_q;
    rd_d = (addr_ok && !hwrite) ? rd_mux(haddr[7:0], pf_word, ck_word, ci_word, st_word) : rd_q;
    pfctrl_d = pfctrl_q;
    clkctrl_d = clkctrl_q;
    ci_d = ci_q;
    if (wr_q) begin
      case (wa_q)
        rpfc_pkg::OFS_PFCTRL: begin
          pfctrl_d.enable = hwdata[rpfc_pkg::PF_EN_BIT];
          pfctrl_d.response_reset = hwdata[rpfc_pkg::PF_RESP_BIT];
          pfctrl_d.detect_off = hwdata[rpfc_pkg::PF_OFF_BIT];
        end
        rpfc_pkg::OFS_CLKCTRL: begin
          clkctrl_d.wdt_reset_sel = hwdata[rpfc_pkg::CK_WDT_RST_BIT];
          clkctrl_d.sub_clk = hwdata[rpfc_pkg::CK_SUB_CLK_BIT];
        end
        rpfc_pkg::OFS_COREINIT: begin
          ci_d.ram_page = hwdata[rpfc_pkg::CI_RPR_LSB +: 8];
          ci_d.dp_flag = hwdata[rpfc_pkg::CI_DP_BIT];
          ci_d.periph_clk_en = hwdata[rpfc_pkg::CI_PCLK_BIT];
          ci_d.wdt_en = hwdata[rpfc_pkg::CI_WDT_BIT];
        end
        default: begin
          ci_d = ci_q;
        end
      endcase
    end
    // any reset source restores control defaults; data ram is not touched
    if (trig) begin
      pfctrl_d = '0;
      clkctrl_d = '0;
      ci_d = '0;
    end
    // registered copy so the output comes from a flip-flop
    det_d = pfctrl_d.enable & ~pfctrl_d.detect_off;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= rpfc_pkg::ST_HOLD;
      cnt_q <= 32'h0;
      low_q <= '0;
      pfc_q <= '0;
      pfctrl_q <= '0;
      clkctrl_q <= '0;
      ci_q <= '0;
      cause_q <= '0;
      vlo_q <= 8'h0;
      pc_q <= 16'h0;
      pcl_q <= 1'b0;
      vrd_q <= 1'b0;
      vad_q <= 16'h0;
      init_q <= 1'b1;
      frz_q <= 1'b0;
      lvl_q <= 2'h0;
      wr_q <= 1'b0;
      wa_q <= 8'h0;
      rd_q <= 32'h0;
      det_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      pfc_q <= pfc_d;
      pfctrl_q <= pfctrl_d;
      clkctrl_q <= clkctrl_d;
      ci_q <= ci_d;
      cause_q <= cause_d;
      vlo_q <= vlo_d;
      pc_q <= pc_d;
      pcl_q <= pcl_d;
      vrd_q <= vrd_d;
      vad_q <= vad_d;
      init_q <= init_d;
      frz_q <= frz_d;
      lvl_q <= lvl_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      rd_q <= rd_d;
      det_q <= det_d;
    end
  end

  // core reset held from power-up until the vector is loaded
  logic crst_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crst_q <= 1'b1;
    end else begin
      crst_q <= (state_d != rpfc_pkg::ST_RUN);
    end
  end

  assign hrdata = rd_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign vec_rd = vrd_q;
  assign vec_addr = vad_q;
  assign pc_value = pc_q;
  assign pc_load = pcl_q;
  assign core_reset = crst_q;
  assign ctrl_init = init_q;
  assign core_freeze = frz_q;
  assign ram_page_reg = ci_q.ram_page;
  assign dp_flag = ci_q.dp_flag;
  assign sub_clk_sel = clkctrl_q.sub_clk;
  assign periph_clk_en = ci_q.periph_clk_en;
  assign wdt_enable = ci_q.wdt_en;
  assign detect_active = det_q;
  assign fail_level_sel_lo = lvl_q[0];
  assign fail_level_sel_hi = lvl_q[1];
endmodule
`default_nettype wire

/* rpfc_far.sv */
// far-side model: reset pin driver, supply monitor, vector memory
`default_nettype none
module rpfc_far #(
  parameter logic [7:0] HI = 8'h00,
  parameter logic [7:0] LO = 8'h00
) (
  input wire logic hclk,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  output var logic [7:0] vec_data,
  output var logic reset_pin_n,
  output var logic supply_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reset_pin_n = 1'b1;
    supply_low = 1'b0;
    vec_data = 8'h00;
  end
  // byte one cycle after read, inverted last value otherwise
  always @(posedge hclk) vec_data <= vec_rd ? (vec_addr == rpfc_pkg::VEC_HI_ADDR ? HI : LO) : ~vec_data;
  // pin low for n cycles, at least 8 in normal use
  task pin(input int n);
    @(posedge hclk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge hclk);
    reset_pin_n <= 1'b1;
  endtask
  task supply(input logic v);
    @(posedge hclk);
    supply_low <= v;
  endtask
endmodule
`default_nettype wire

/* rpfc_assertions.sv */
// checker module and bind for the reset and power-fail control
`default_nettype none
module rpfc_chk #(
  parameter int unsigned STARTUP_CYC = 20,
  parameter logic [1:0] MASK_LEVEL = 2'h0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reset_pin_n,
  input wire logic supply_low,
  input wire logic otp_part,
  input wire logic cfg_fail_level_lo,
  input wire logic cfg_fail_level_hi,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic pc_load,
  input wire logic core_reset,
  input wire logic ctrl_init,
  input wire logic core_freeze,
  input wire logic [7:0] ram_page_reg,
  input wire logic dp_flag,
  input wire logic sub_clk_sel,
  input wire logic periph_clk_en,
  input wire logic wdt_enable,
  input wire logic detect_active,
  input wire logic fail_level_sel_lo,
  input wire logic fail_level_sel_hi
);
  logic [31:0] wait_q;
  logic [31:0] wait_d;
  logic [3:0] low_q;
  logic [3:0] low_d;
  always_comb begin
    wait_d = (!reset_pin_n || ctrl_init) ? 32'h0 : wait_q + {31'h0, core_reset};
    low_d = reset_pin_n ? 4'h0 : (low_q == 4'hF ? low_q : low_q + 4'h1);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 32'h0;
      low_q <= 4'h0;
    end else begin
      wait_q <= wait_d;
      low_q <= low_d;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  pc_drop_a: assert property (pc_load |-> !core_reset && $past(core_reset))
    else $error("pc load without reset release");
  vec_order_a: assert property (vec_rd && vec_addr == 16'hFFFE |-> ##[1:3] vec_rd && vec_addr == 16'hFFFF ##[1:3] pc_load)
    else $error("vector fetch order wrong");
  startup_wait_a: assert property (pc_load |-> wait_q >= STARTUP_CYC + 7 && wait_q <= STARTUP_CYC + 19)
    else $error("start-up delay wrong");
  init_core_a: assert property (ctrl_init |-> core_reset ##1 core_reset)
    else $error("core reset not held");
  init_clear_a: assert property (ctrl_init |-> ##[0:2] (ram_page_reg == 8'h00 && !dp_flag && !periph_clk_en
    && !wdt_enable && !sub_clk_sel && !detect_active)) else $error("control state not cleared");
  pin_accept_a: assert property (low_q == 4'h8 |-> ##[1:6] core_reset)
    else $error("long pin low not accepted");
  pf_resp_a: assert property ((detect_active && supply_low) [*8] |-> ##[0:3] (core_freeze || ctrl_init))
    else $error("no power fail response");
  pf_gate_a: assert property ($rose(core_freeze) |-> $past(detect_active) && $past(supply_low, 3))
    else $error("freeze without enabled detection");
  level_sel_a: assert property ($stable({otp_part, cfg_fail_level_hi, cfg_fail_level_lo}) [*3] |->
    {fail_level_sel_hi, fail_level_sel_lo} == (otp_part ? {cfg_fail_level_hi, cfg_fail_level_lo} : MASK_LEVEL))
    else $error("level select wrong");
  cover property ($rose(core_freeze));
  cover property (pc_load);
  cover property (ctrl_init ##1 !ctrl_init);
endmodule
bind rpfc_top rpfc_chk #(.STARTUP_CYC(STARTUP_CYC), .MASK_LEVEL(MASK_LEVEL)) chk (.*);
`default_nettype wire

/* tb.sv */
// self-checking testbench for the reset and power-fail control
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 20;
  localparam logic [1:0] ML = 2'h2;
  localparam logic [15:0] PCV = 16'hC33C;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, reset_pin_n, supply_low, wdt_expire, otp_part;
  logic cfg_fail_level_lo, cfg_fail_level_hi, vec_rd, pc_load, core_reset, ctrl_init, core_freeze, dp_flag;
  logic sub_clk_sel, periph_clk_en, wdt_enable, detect_active, fail_level_sel_lo, fail_level_sel_hi, seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] vec_data, ram_page_reg;
  logic [15:0] vec_addr, pc_value;
  int fails, checked, cyc;
  assign hready = hreadyout;
  rpfc_top #(.STARTUP_CYC(SC), .MASK_LEVEL(ML)) uut (.*);
  rpfc_far #(.HI(PCV[15:8]), .LO(PCV[7:0])) far (.*);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) if (ctrl_init === 1'b1) seen <= 1'b1;
  task report_and_stop;
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task zchk;
    chk({19'h0, ram_page_reg, dp_flag, periph_clk_en, wdt_enable, sub_clk_sel, detect_active}, 32'h0);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= rpfc_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
    @(negedge hclk);
  endtask
  task wait_pc;
    cyc = 0;
    while (pc_load !== 1'b1 && cyc < SC + 100) begin
      @(negedge hclk);
      cyc++;
    end
    chk({31'h0, pc_load}, 32'h1);
    chk({16'h0, pc_value}, {16'h0, PCV});
    chk({31'h0, core_reset}, 32'h0);
  endtask
  task wdt_pulse;
    @(posedge hclk);
    wdt_expire <= 1'b1;
    @(posedge hclk);
    wdt_expire <= 1'b0;
    repeat (4) @(negedge hclk);
  endtask
  task t_boot;
    @(negedge hclk);
    zchk();
    chk({31'h0, core_reset}, 32'h1);
    wait_pc();
    chk({31'h0, cyc >= SC + 7}, 32'h1);
    bus(1'b0, rpfc_pkg::OFS_COREINIT, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_pin;
    bus(1'b1, rpfc_pkg::OFS_COREINIT, 32'h0000_07A5);
    bus(1'b1, rpfc_pkg::OFS_CLKCTRL, 32'h2);
    seen = 1'b0;
    far.pin(7);
    repeat (20) @(negedge hclk);
    chk({31'h0, seen || core_reset}, 32'h0);
    chk({24'h0, ram_page_reg}, 32'hA5);
    far.pin(8);
    repeat (6) @(negedge hclk);
    chk({30'h0, seen, core_reset}, 32'h3);
    zchk();
    bus(1'b0, rpfc_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[rpfc_pkg::ST_EXT_BIT]}, 32'h1);
    wait_pc();
  endtask
  task t_wdt;
    bus(1'b1, rpfc_pkg::OFS_COREINIT, 32'h0000_07FF);
    wdt_pulse();
    chk({30'h0, core_reset, wdt_enable}, 32'h1);
    bus(1'b1, rpfc_pkg::OFS_CLKCTRL, 32'h1);
    seen = 1'b0;
    wdt_pulse();
    chk({30'h0, seen, core_reset}, 32'h3);
    zchk();
    bus(1'b0, rpfc_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[rpfc_pkg::ST_WDT_BIT]}, 32'h1);
    wait_pc();
  endtask
  task pf_run(input logic [31:0] ctl, input logic [1:0] exp);
    bus(1'b1, rpfc_pkg::OFS_PFCTRL, ctl);
    seen = 1'b0;
    far.supply(1'b1);
    repeat (14) @(negedge hclk);
    chk({30'h0, seen, core_freeze}, {30'h0, exp});
    far.supply(1'b0);
    repeat (8) @(negedge hclk);
  endtask
  task t_pf;
    pf_run(32'h5, 2'h0);
    pf_run(32'h1, 2'h1);
    chk({31'h0, core_freeze}, 32'h0);
    pf_run(32'h3, 2'h2);
    bus(1'b0, rpfc_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[rpfc_pkg::ST_PF_BIT]}, 32'h1);
    bus(1'b0, rpfc_pkg::OFS_PFCTRL, 32'h0);
    chk(rd, 32'h0);
    wait_pc();
  endtask
  task t_lvl;
    logic [2:0] i;
    for (int k = 0; k < 8; k++) begin
      i = 3'(k);
      @(posedge hclk);
      otp_part <= i[2];
      cfg_fail_level_hi <= i[1];
      cfg_fail_level_lo <= i[0];
      repeat (4) @(negedge hclk);
      chk({30'h0, fail_level_sel_hi, fail_level_sel_lo}, {30'h0, i[2] ? i[1:0] : ML});
    end
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
  endtask
  initial begin
    repeat (5000) @(posedge hclk);
    fails++;
    report_and_stop();
  end
  initial begin
    {hresetn, hsel, hwrite, wdt_expire, otp_part, cfg_fail_level_lo, cfg_fail_level_hi, seen} = 8'h00;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    fails = 0;
    checked = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_boot();
    t_pin();
    t_wdt();
    t_pf();
    t_lvl();
    report_and_stop();
  end
endmodule
`default_nettype wire
